//--- rtl/fsp_params.svh
// Register indices, field positions, reset values and timing counts of the serial port
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define FSP_IDX_CTRL 10'h098
`define FSP_IDX_BUF 10'h099
`define FSP_IDX_BAUD 10'h09A

// =====================================================================
// Control register fields
`define FSP_B_MODE_HI 7
`define FSP_B_MODE_LO 6
`define FSP_B_FILT 5
`define FSP_B_REN 4
`define FSP_B_TB8 3
`define FSP_B_RB8 2
`define FSP_B_TXDONE 1
`define FSP_B_RXDONE 0
`define FSP_CTRL_RST 8'h00

// =====================================================================
// Baud select register fields
`define FSP_B_BDBL 0
`define FSP_B_TXSRC 1
`define FSP_B_RXSRC 2
`define FSP_BAUD_RST 3'h0

// =====================================================================
// Mode codes
`define FSP_MODE_SHIFT 2'h0
`define FSP_MODE_A8 2'h1
`define FSP_MODE_A9F 2'h2
`define FSP_MODE_A9V 2'h3

// =====================================================================
// Timing: 16 samples per bit, fixed-rate sample dividers
`define FSP_OS_LAST 4'hF
`define FSP_OS_MID 4'h7
`define FSP_FIX_DIV 3'h4
`define FSP_FIX_DIV_DBL 3'h2
`define FSP_TX_BITS8 4'h9
`define FSP_TX_BITS9 4'hA
`define FSP_RX_NINTH 4'h8
`define FSP_RX_STOP9 4'h9
`define FSP_M0_LAST 3'h7

`endif

//--- rtl/fsp_pkg.sv
// State types of the serial port
package fsp_pkg;
  typedef enum logic [1:0] {FSP_TX_IDLE, FSP_TX_WAIT, FSP_TX_SEND} fsp_tx_state_e;
  typedef enum logic [1:0] {FSP_RX_IDLE, FSP_RX_START, FSP_RX_BITS} fsp_rx_state_e;
  typedef enum logic [1:0] {FSP_S0_IDLE, FSP_S0_LOW, FSP_S0_HIGH} fsp_m0_state_e;
endpackage

//--- rtl/fsp_baud.sv
// Sample tick source: timer overflow select or fixed core divider
`timescale 1ns/1ns
module fsp_baud
  import fsp_pkg::*;
#(
  parameter int DIV_W = 3
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic fixed_rate,
  input wire logic baud_double,
  input wire logic src_sel,
  // Overflow ticks
  input wire logic ovf_a_tick,
  input wire logic ovf_b_tick,
  // Sample tick
  output logic os_tick
);
`include "fsp_params.svh"

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic os_reg;
  logic os_next;
  logic [DIV_W-1:0] div_top;

  // Divider must hold the fixed divide count
  if (DIV_W < 3)
  begin
    $error("fsp_baud: DIV_W too small");
  end

  // =====================================================================
  // Divider
  always_comb
  begin
    div_top = baud_double ? DIV_W'(`FSP_FIX_DIV_DBL) : DIV_W'(`FSP_FIX_DIV);
    div_next = div_reg;
    os_next = 1'b0;
    if (fixed_rate)
    begin
      if (div_reg >= div_top - DIV_W'(1))
      begin
        div_next = '0;
        os_next = 1'b1;
      end
      else
        div_next = div_reg + DIV_W'(1);
    end
    else
    begin
      div_next = '0;
      os_next = src_sel ? ovf_b_tick : ovf_a_tick; // [RL16]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= '0;
      os_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      os_reg <= os_next;
    end
  end

  assign os_tick = os_reg;

endmodule

//--- rtl/fsp_serial_port.sv
// Four-mode serial port with APB register access
// Functional notes
// RL1: Transmit and receive paths run independently
// RL2: Receive shift continues while buffer unread
// RL3: Buffer write loads transmit, read returns receive
// RL4: Two mode bits select one of four modes
// RL5: 8-bit mode filter requires valid stop bit
// RL6: 9-bit mode filter requires ninth bit one
// RL7: Software keeps filter cleared in shift mode
// RL8: Reception only while receive enable set
// RL9: 9-bit modes send programmed ninth bit
// RL10: Ninth bit or stop bit stored
// RL11: Transmit done set at stop start
// RL12: Receive done set at stop middle
// RL13: Shift mode: data on rx, clock on tx
// RL14: Shift receive starts when enabled, flag clear
// RL15: 8-bit frame: start, eight data, stop
// RL16: Each direction picks its own timer source
// RL17: 8-bit write loads stop bit one
// RL18: Async receive starts on falling edge
// RL19: Load only if flag clear and filter passes
// RL20: Fixed rate core/64, or core/32 doubled
// RL21: 9-bit frame: start, data, ninth, stop
// RL22: Fixed-rate transmit waits for next bit tick
// RL23: Variable 9-bit mode uses timer ticks
// RL24: Variable rate bit is sixteen ticks
// RL25: Async receive only on start bit, enabled
// RL26: Separate tick inputs oversample receive pin
// RL27: Interrupt request is OR of flags
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module fsp_serial_port
  import fsp_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer overflow ticks
  input wire logic ovf_a_tick,
  input wire logic ovf_b_tick,
  // Serial pins
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe_n,
  output logic tx_pin,
  // Interrupt request
  output logic irq
);
`include "fsp_params.svh"

  // Decoder reads address bits up to 11
  if (ADDR_W < 12)
  begin
    $error("fsp_serial_port: ADDR_W must be at least 12");
  end

  // =====================================================================
  // Declarations
  logic [7:0] ctrl_reg, ctrl_next;
  logic [2:0] baud_reg, baud_next;
  logic [7:0] rx_buf_reg, rx_buf_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  fsp_tx_state_e tx_state_reg, tx_state_next;
  logic [9:0] tx_shift_reg, tx_shift_next;
  logic [3:0] tx_left_reg, tx_left_next;
  logic [3:0] tx_div_reg, tx_div_next;
  logic tx_line_reg, tx_line_next;
  fsp_rx_state_e rx_state_reg, rx_state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bitn_reg, rx_bitn_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic rx9_reg, rx9_next;
  logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
  fsp_m0_state_e m0_state_reg, m0_state_next;
  logic [2:0] m0_cnt_reg, m0_cnt_next;
  logic [7:0] m0_shift_reg, m0_shift_next;
  logic m0_is_tx_reg, m0_is_tx_next;
  logic rx_pin_out_reg, rx_pin_out_next;
  logic rx_pin_oe_n_reg, rx_pin_oe_n_next;
  logic tx_pin_reg, tx_pin_next;
  logic [1:0] mode;
  logic is_shift, is_a8, is_fixed;
  logic ren, filt, rx_done;
  logic acc, hit_ctrl, hit_buf, hit_baud, wr_buf;
  logic tx_os, rx_os, tx_bit_tick;
  logic tx_done_ev, a_final, a_ninth, a_load;
  logic m0_tx_done, m0_rx_load;

  // =====================================================================
  // Decode
  assign mode = {ctrl_reg[`FSP_B_MODE_HI], ctrl_reg[`FSP_B_MODE_LO]}; // [RL4]
  assign is_shift = (mode == `FSP_MODE_SHIFT);
  assign is_a8 = (mode == `FSP_MODE_A8);
  assign is_fixed = (mode == `FSP_MODE_A9F);
  assign ren = ctrl_reg[`FSP_B_REN];
  assign filt = ctrl_reg[`FSP_B_FILT];
  assign rx_done = ctrl_reg[`FSP_B_RXDONE];
  assign acc = psel && penable && pready_reg;
  assign hit_ctrl = (paddr[11:2] == `FSP_IDX_CTRL);
  assign hit_buf = (paddr[11:2] == `FSP_IDX_BUF);
  assign hit_baud = (paddr[11:2] == `FSP_IDX_BAUD);
  assign wr_buf = acc && pwrite && hit_buf; // [RL3]

  // =====================================================================
  // Sample tick sources, one per direction
  fsp_baud #(.DIV_W(3)) u_tx_baud (
    .pclk(pclk),
    .presetn(presetn),
    .fixed_rate(is_fixed), // [RL20]
    .baud_double(baud_reg[`FSP_B_BDBL]),
    .src_sel(baud_reg[`FSP_B_TXSRC]),
    .ovf_a_tick(ovf_a_tick),
    .ovf_b_tick(ovf_b_tick),
    .os_tick(tx_os)
  );

  fsp_baud #(.DIV_W(3)) u_rx_baud (
    .pclk(pclk),
    .presetn(presetn),
    .fixed_rate(is_fixed),
    .baud_double(baud_reg[`FSP_B_BDBL]),
    .src_sel(baud_reg[`FSP_B_RXSRC]), // [RL16] [RL26]
    .ovf_a_tick(ovf_a_tick),
    .ovf_b_tick(ovf_b_tick),
    .os_tick(rx_os)
  );

  // =====================================================================
  // Registers and APB answer
  always_comb
  begin
    ctrl_next = ctrl_reg;
    baud_next = baud_reg;
    rx_buf_next = rx_buf_reg;
    pready_next = psel && penable && !pready_reg;
    prdata_next = 32'h0;
    pslverr_next = 1'b0;
    if (pready_next)
    begin
      pslverr_next = !(hit_ctrl || hit_buf || hit_baud);
      if (hit_ctrl)
        prdata_next = {24'h0, ctrl_reg};
      else if (hit_buf)
        prdata_next = {24'h0, rx_buf_reg}; // [RL3]
      else if (hit_baud)
        prdata_next = {29'h0, baud_reg};
    end
    if (acc && pwrite && hit_ctrl)
      ctrl_next = pwdata[7:0];
    if (acc && pwrite && hit_baud)
      baud_next = pwdata[2:0];
    if (tx_done_ev || m0_tx_done)
      ctrl_next[`FSP_B_TXDONE] = 1'b1; // [RL11]
    if (a_load)
    begin
      rx_buf_next = rx_shift_reg; // [RL19]
      ctrl_next[`FSP_B_RB8] = a_ninth; // [RL10]
      ctrl_next[`FSP_B_RXDONE] = 1'b1; // [RL12]
    end
    else if (m0_rx_load)
    begin
      rx_buf_next = m0_shift_next;
      ctrl_next[`FSP_B_RXDONE] = 1'b1;
    end
    irq_next = ctrl_next[`FSP_B_TXDONE] || ctrl_next[`FSP_B_RXDONE]; // [RL27]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `FSP_CTRL_RST;
      baud_reg <= `FSP_BAUD_RST;
      rx_buf_reg <= 8'h00;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      baud_reg <= baud_next;
      rx_buf_reg <= rx_buf_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
    end
  end

  // =====================================================================
  // Asynchronous transmitter
  assign tx_bit_tick = tx_os && (tx_div_reg == `FSP_OS_LAST); // [RL24]

  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_left_next = tx_left_reg;
    tx_line_next = tx_line_reg;
    tx_div_next = tx_os ? tx_div_reg + 4'h1 : tx_div_reg;
    tx_done_ev = 1'b0;
    if (is_shift)
    begin
      tx_state_next = FSP_TX_IDLE;
      tx_line_next = 1'b1;
    end
    else if (wr_buf)
    begin
      tx_state_next = FSP_TX_WAIT;
      tx_shift_next[7:0] = pwdata[7:0];
      tx_shift_next[9] = 1'b1;
      tx_shift_next[8] = is_a8 ? 1'b1 : ctrl_reg[`FSP_B_TB8]; // [RL17] [RL9]
    end
    else
    begin
      unique case (tx_state_reg)
        FSP_TX_IDLE:
          tx_line_next = 1'b1;
        FSP_TX_WAIT:
          if (tx_bit_tick) // [RL22] [RL23]
          begin
            tx_line_next = 1'b0;
            tx_left_next = is_a8 ? `FSP_TX_BITS8 : `FSP_TX_BITS9; // [RL15] [RL21]
            tx_state_next = FSP_TX_SEND;
          end
        FSP_TX_SEND:
          if (tx_bit_tick)
          begin
            if (tx_left_reg == 4'h0)
              tx_state_next = FSP_TX_IDLE;
            else
            begin
              tx_line_next = tx_shift_reg[0];
              tx_shift_next = {1'b1, tx_shift_reg[9:1]};
              tx_left_next = tx_left_reg - 4'h1;
              tx_done_ev = (tx_left_reg == 4'h1); // [RL11]
            end
          end
        default:
          tx_state_next = FSP_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= FSP_TX_IDLE;
      tx_shift_reg <= 10'h3FF;
      tx_left_reg <= 4'h0;
      tx_div_reg <= 4'h0;
      tx_line_reg <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_left_reg <= tx_left_next;
      tx_div_reg <= tx_div_next;
      tx_line_reg <= tx_line_next;
    end
  end

  // =====================================================================
  // Asynchronous receiver
  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_os ? rx_cnt_reg + 4'h1 : rx_cnt_reg;
    rx_bitn_next = rx_bitn_reg;
    rx_shift_next = rx_shift_reg;
    rx9_next = rx9_reg;
    a_final = 1'b0;
    a_ninth = is_a8 ? rx_sync_reg : rx9_reg; // [RL10]
    if (!ren || is_shift)
      rx_state_next = FSP_RX_IDLE; // [RL8]
    else
    begin
      unique case (rx_state_reg)
        FSP_RX_IDLE:
          if (rx_prev_reg && !rx_sync_reg) // [RL18] [RL25]
          begin
            rx_state_next = FSP_RX_START;
            rx_cnt_next = 4'h0;
          end
        FSP_RX_START:
          if (rx_os && rx_cnt_reg == `FSP_OS_MID)
          begin
            rx_cnt_next = 4'h0;
            rx_bitn_next = 4'h0;
            rx_state_next = rx_sync_reg ? FSP_RX_IDLE : FSP_RX_BITS;
          end
        FSP_RX_BITS:
          if (rx_os && rx_cnt_reg == `FSP_OS_LAST) // [RL26]
          begin
            rx_bitn_next = rx_bitn_reg + 4'h1;
            if (rx_bitn_reg < `FSP_RX_NINTH)
              rx_shift_next = {rx_sync_reg, rx_shift_reg[7:1]}; // [RL2]
            else if (is_a8 || rx_bitn_reg == `FSP_RX_STOP9)
            begin
              a_final = 1'b1;
              rx_state_next = FSP_RX_IDLE;
            end
            else
              rx9_next = rx_sync_reg;
          end
        default:
          rx_state_next = FSP_RX_IDLE;
      endcase
    end
    a_load = a_final && !rx_done && (!filt || a_ninth); // [RL19] [RL5] [RL6]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg <= FSP_RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_bitn_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx9_reg <= 1'b0;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bitn_reg <= rx_bitn_next;
      rx_shift_reg <= rx_shift_next;
      rx9_reg <= rx9_next;
      rx_meta_reg <= rx_pin_in;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // =====================================================================
  // Shift-register mode and pin drivers
  always_comb
  begin
    m0_state_next = m0_state_reg;
    m0_cnt_next = m0_cnt_reg;
    m0_shift_next = m0_shift_reg;
    m0_is_tx_next = m0_is_tx_reg;
    m0_tx_done = 1'b0;
    m0_rx_load = 1'b0;
    if (!is_shift || (m0_state_reg != FSP_S0_IDLE && !m0_is_tx_reg && !ren))
      m0_state_next = FSP_S0_IDLE;
    else
    begin
      unique case (m0_state_reg)
        FSP_S0_IDLE:
          if (wr_buf) // [RL13]
          begin
            m0_state_next = FSP_S0_LOW;
            m0_shift_next = pwdata[7:0];
            m0_is_tx_next = 1'b1;
            m0_cnt_next = 3'h0;
          end
          else if (ren && !rx_done) // [RL14]
          begin
            m0_state_next = FSP_S0_LOW;
            m0_is_tx_next = 1'b0;
            m0_cnt_next = 3'h0;
          end
        FSP_S0_LOW:
          m0_state_next = FSP_S0_HIGH;
        FSP_S0_HIGH:
        begin
          m0_shift_next = {rx_sync_reg, m0_shift_reg[7:1]};
          m0_cnt_next = m0_cnt_reg + 3'h1;
          m0_state_next = FSP_S0_LOW;
          if (m0_cnt_reg == `FSP_M0_LAST)
          begin
            m0_state_next = FSP_S0_IDLE;
            m0_tx_done = m0_is_tx_reg; // [RL11]
            m0_rx_load = !m0_is_tx_reg; // [RL12]
          end
        end
        default:
          m0_state_next = FSP_S0_IDLE;
      endcase
    end
    rx_pin_out_next = m0_shift_next[0];
    rx_pin_oe_n_next = !(m0_is_tx_next && m0_state_next != FSP_S0_IDLE);
    tx_pin_next = is_shift ? (m0_state_next != FSP_S0_LOW) : tx_line_next; // [RL13] [RL1]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m0_state_reg <= FSP_S0_IDLE;
      m0_cnt_reg <= 3'h0;
      m0_shift_reg <= 8'h00;
      m0_is_tx_reg <= 1'b0;
      rx_pin_out_reg <= 1'b0;
      rx_pin_oe_n_reg <= 1'b1;
      tx_pin_reg <= 1'b1;
    end
    else
    begin
      m0_state_reg <= m0_state_next;
      m0_cnt_reg <= m0_cnt_next;
      m0_shift_reg <= m0_shift_next;
      m0_is_tx_reg <= m0_is_tx_next;
      rx_pin_out_reg <= rx_pin_out_next;
      rx_pin_oe_n_reg <= rx_pin_oe_n_next;
      tx_pin_reg <= tx_pin_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_pin_out = rx_pin_out_reg;
  assign rx_pin_oe_n = rx_pin_oe_n_reg;
  assign tx_pin = tx_pin_reg;
  assign irq = irq_reg;

  // =====================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_or_flags_a: assert property ( // [RL27]
    irq == (ctrl_reg[`FSP_B_TXDONE] || ctrl_reg[`FSP_B_RXDONE]))
    else $error("irq differs from flag OR");
  rx_flag_gate_a: assert property (a_final && rx_done |=> $stable(rx_buf_reg)) // [RL19]
    else $error("buffer overwritten while flag set");
  rx_filter_a: assert property ( // [RL6]
    a_final && !is_a8 && filt && !rx9_reg |=> $stable(rx_buf_reg))
    else $error("ninth-bit filter passed a zero");
  tx_stop_a: assert property (tx_done_ev |=> tx_line_reg && ctrl_reg[`FSP_B_TXDONE]) // [RL11]
    else $error("tx flag not set at stop start");
  ren_off_a: assert property (!ren |=> rx_state_reg == FSP_RX_IDLE) // [RL8]
    else $error("receiver ran while disabled");
  m0_clock_a: assert property ( // [RL13]
    is_shift && $stable(is_shift) |-> tx_pin_reg == (m0_state_reg != FSP_S0_LOW))
    else $error("shift clock wrong");
  tx_wait_a: assert property ( // [RL22]
    tx_state_reg == FSP_TX_WAIT && !tx_bit_tick && !wr_buf && !is_shift
    |=> tx_state_reg == FSP_TX_WAIT)
    else $error("transmit left wait off tick");
  tx_start_bit_a: assert property ( // [RL15]
    tx_state_reg == FSP_TX_WAIT && tx_bit_tick && !wr_buf && !is_shift
    |=> !tx_line_reg ##1 !tx_line_reg)
    else $error("start bit not low");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

  tx_frame_c: cover property (tx_state_reg == FSP_TX_SEND ##[1:1000] tx_done_ev);
  rx_load_c: cover property (a_load);
  m0_rx_c: cover property (m0_rx_load);
  rx_drop_c: cover property (a_final && rx_done);

endmodule

//--- tb/fsp_remote_node.sv
// Remote serial node model: frame sender and transmit line capture
`timescale 1ns/1ns
module fsp_remote_node
(
  // Clock
  input wire logic pclk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_drive
);
  initial rx_drive = 1'b1;

  // ==========================================================
  // Sender: start, data LSB first, optional ninth bit, stop
  task automatic send(input logic [7:0] d, input logic nine, input logic b9,
    input int per);
    logic [10:0] f;
    int n;
    f = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      rx_drive <= f[i];
      repeat (per) @(posedge pclk);
    end
  endtask

  // ==========================================================
  // Capture: samples each bit at its centre
  task automatic recv(input int per, input logic nine, output logic [7:0] d,
    output logic b9, output logic stp);
    @(negedge tx_line);
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (per) @(posedge pclk);
      d[i] = tx_line;
    end
    b9 = 1'b0;
    if (nine)
    begin
      repeat (per) @(posedge pclk);
      b9 = tx_line;
    end
    repeat (per) @(posedge pclk);
    stp = tx_line;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench of the four-mode serial port
`timescale 1ns/1ns
`include "fsp_params.svh"
module tb;
  localparam logic [11:0] A_CTRL = {`FSP_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_BUF = {`FSP_IDX_BUF, 2'b00};
  localparam logic [11:0] A_BAUD = {`FSP_IDX_BAUD, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ovf_a_tick = 1'b0;
  logic ovf_b_tick = 1'b0;
  logic rx_pin_out;
  logic rx_pin_oe_n;
  logic tx_pin;
  logic irq;
  logic node_drv;
  logic rx_line;
  logic [1:0] tick_cnt = 2'h0;
  int fails = 0;
  int cmp_count = 0;

  // Receive pin: design drives it only with its enable low
  assign rx_line = rx_pin_oe_n ? node_drv : rx_pin_out;

  fsp_serial_port dut
  (
    .pclk,
    .presetn,
    .psel,
    .penable,
    .pwrite,
    .paddr,
    .pwdata,
    .prdata,
    .pready,
    .pslverr,
    .ovf_a_tick,
    .ovf_b_tick,
    .rx_pin_in(rx_line),
    .rx_pin_out,
    .rx_pin_oe_n,
    .tx_pin,
    .irq
  );

  fsp_remote_node node
  (
    .pclk,
    .tx_line(tx_pin),
    .rx_drive(node_drv)
  );

  initial
  begin
    forever #2 pclk = ~pclk;
  end

  // Source A ticks every 2 clocks, source B every 4
  always @(posedge pclk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    ovf_a_tick <= tick_cnt[0];
    ovf_b_tick <= (tick_cnt == 2'h3);
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "apb answer");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd_chk(A_CTRL, 32'h0, "ctrl reset");
    rd_chk(A_BAUD, 32'h0, "baud reset");
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    $display("t_reset done");
  endtask

  task automatic t_shift_tx();
    logic [7:0] got;
    fork
      wr(A_BUF, 8'h96);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge tx_pin);
        got[i] = rx_pin_out;
        chk({31'h0, rx_pin_oe_n}, 32'h0, "shift drive enable");
      end
    join
    chk({24'h0, got}, 32'h96, "shift data");
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq");
    rd_chk(A_CTRL, 32'h02, "shift tx done");
    wr(A_CTRL, 8'h10);
    repeat (24) @(posedge pclk);
    rd_chk(A_BUF, 32'hFF, "shift rx data");
    rd_chk(A_CTRL, 32'h11, "shift rx done");
    $display("t_shift_tx done");
  endtask

  task automatic t_duplex();
    logic [7:0] d;
    logic b9;
    logic stp;
    wr(A_BAUD, 8'h04);
    wr(A_CTRL, 8'h50);
    fork
      node.send(8'h3C, 1'b0, 1'b0, 64);
      wr(A_BUF, 8'hC3);
      node.recv(32, 1'b0, d, b9, stp);
    join
    repeat (8) @(posedge pclk);
    chk({24'h0, d}, 32'hC3, "8-bit tx data");
    chk({31'h0, stp}, 32'h1, "8-bit stop");
    rd_chk(A_BUF, 32'h3C, "8-bit rx data");
    rd_chk(A_CTRL, 32'h57, "8-bit flags");
    $display("t_duplex done");
  endtask

  task automatic t_ninth_tx();
    logic [7:0] cfg [3] = '{8'h88, 8'h80, 8'hC8};
    logic [7:0] d;
    logic b9;
    logic stp;
    for (int k = 0; k < 3; k++)
    begin
      wr(A_BAUD, (k == 1) ? 8'h01 : 8'h00);
      wr(A_CTRL, cfg[k]);
      fork
        wr(A_BUF, 8'hA5 ^ k[7:0]);
        node.recv((k == 0) ? 64 : 32, 1'b1, d, b9, stp);
      join
      chk({24'h0, d}, {24'h0, 8'hA5 ^ k[7:0]}, "9-bit data");
      chk({31'h0, b9}, {31'h0, cfg[k][3]}, "9-bit ninth");
      chk({31'h0, stp}, 32'h1, "9-bit stop");
      rd_chk(A_CTRL, {24'h0, cfg[k] | 8'h02}, "9-bit tx done");
    end
    $display("t_ninth_tx done");
  endtask

  task automatic t_filter_rx();
    wr(A_BAUD, 8'h00);
    wr(A_CTRL, 8'hB0);
    node.send(8'h11, 1'b1, 1'b0, 64);
    repeat (8) @(posedge pclk);
    rd_chk(A_CTRL, 32'hB0, "filtered flags");
    rd_chk(A_BUF, 32'h3C, "filtered buffer");
    node.send(8'h5A, 1'b1, 1'b1, 64);
    repeat (8) @(posedge pclk);
    rd_chk(A_CTRL, 32'hB5, "address flags");
    node.send(8'h77, 1'b1, 1'b1, 64);
    repeat (8) @(posedge pclk);
    rd_chk(A_BUF, 32'h5A, "overrun buffer");
    wr(A_CTRL, 8'h80);
    node.send(8'h66, 1'b1, 1'b1, 64);
    repeat (8) @(posedge pclk);
    rd_chk(A_CTRL, 32'h80, "disabled flags");
    rd_chk(A_BUF, 32'h5A, "disabled buffer");
    $display("t_filter_rx done");
  endtask

  // ==========================================================
  // Verdict
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_shift_tx();
    t_duplex();
    t_ninth_tx();
    t_filter_rx();
    complete_run();
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    fails++;
    complete_run();
  end
endmodule
